// *** rtl/pbh_cfg.svh ***
`ifndef PBH_CFG_SVH
`define PBH_CFG_SVH
// Address and data widths of the external port.
`define PBH_ADDR_W 24
`define PBH_DATA_W 32
// Number of decoded page strobes and the lowest address bit of the page field.
`define PBH_PAGES 4
`define PBH_PAGE_LSB 22
// Reset value of the data keeper.
`define PBH_KEEP_RST 32'h0000_0000
// Access cycles in which the synchronised ready still shows the level from before the strobe.
`define PBH_RDY_SKIP 2
`endif

// *** rtl/pbh_pkg.sv ***
package pbh_pkg;
    // One request from the core side of the port.
    typedef struct packed {
        logic rd;          // High for a read, low for a write.
        logic [23:0] addr; // Word address.
        logic [31:0] wdata; // Write data.
    } pbh_req_s;
    // Port sequencer states.
    typedef enum logic [1:0] {
        PBH_IDLE,
        PBH_ACCESS,
        PBH_HELD
    } pbh_state_e;
endpackage

// *** rtl/pbh_sync2.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser; the first stage feeds only the second.
module pbh_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_in, // Clock.
    input wire logic rstn_in, // Asynchronous reset, active low.
    input wire logic [W-1:0] d_in, // Asynchronous inputs.
    output logic [W-1:0] q_out // Synchronised outputs.
);
    logic [W-1:0] meta_q; // First stage, read only by the second.
    // Both stages reset to the idle level so nothing fires at release.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule

// *** rtl/pbh_port.sv ***
`timescale 1ns/1ps
`include "pbh_cfg.svh"
module pbh_port
    import pbh_pkg::*;
(
    input wire logic clk_in, // Processor clock, 20 MHz.
    input wire logic rstn_in, // Asynchronous reset, active low.
    input wire logic shutdown_float_n_in, // Shutdown pin, active low.
    input wire logic ignore_release_bit_in, // Control bit: ignore hold requests.
    input wire logic req_valid_in, // Core request valid.
    output logic req_ready_out, // Core request accepted this cycle.
    input wire pbh_pkg::pbh_req_s req_in, // Core request contents.
    output logic rsp_valid_out, // One-cycle pulse: access completed.
    output logic [31:0] rsp_rdata_out, // Read data, registered.
    output logic [23:0] ext_addr_bus_out, // Address pins.
    output logic ext_addr_bus_oe_out, // Address drive enable.
    input wire logic [31:0] ext_data_bus_in, // Data pins, sampled.
    output logic [31:0] ext_data_bus_out, // Data drive value.
    output logic ext_data_bus_oe_out, // Data drive enable.
    output logic rd_wr_n_out, // Direction: high read, low write.
    output logic rd_wr_n_oe_out, // Direction drive enable.
    output logic access_strobe_n_out, // Common strobe, active low.
    output logic access_strobe_n_oe_out, // Strobe drive enable.
    output logic [3:0] page_select_n_out, // Page strobes, active low.
    output logic page_select_n_oe_out, // Page strobe drive enable.
    input wire logic ready_n_in, // Ready from addressed device, active low.
    input wire logic hold_req_n_in, // Hold request, active low.
    output logic bus_release_ack_n_out, // Hold acknowledge, active low.
    output logic bus_release_ack_n_oe_out // Hold acknowledge drive enable.
);
    import pbh_pkg::*;

    localparam int AW = `PBH_ADDR_W; // Address width.
    localparam int DW = `PBH_DATA_W; // Data width.
    localparam int NP = `PBH_PAGES; // Page count.

    pbh_state_e state_q; // Sequencer state.
    pbh_req_s cur_q; // Request being served.
    logic [DW-1:0] rdata_q; // Captured read data.
    logic rsp_q; // Completion pulse.
    logic [DW-1:0] keep_q; // Data keeper level.
    logic [NP-1:0] page_q; // Decoded page strobes, active low.
    logic [2:0] pin_s; // Synchronised ready, hold, shutdown.
    logic rdy_s; // Synchronised ready, active low.
    logic hold_s; // Synchronised hold, active low.
    logic shz_s; // Synchronised shutdown, active low.
    logic hold_want; // Hold honoured this cycle.
    logic bus_on; // Bus drivers enabled.
    logic [1:0] lat_q; // Cycles spent in the current access, saturating.
    logic acc_done; // Ready seen once the synchroniser has caught up with the strobe.

    // All three pins come from outside the clock domain, so they pass two flops.
    pbh_sync2 #(.W(3), .RST_VAL(3'h7)) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .d_in({ready_n_in, hold_req_n_in, shutdown_float_n_in}),
        .q_out(pin_s)
    );
    assign rdy_s = pin_s[2];
    assign hold_s = pin_s[1];
    assign shz_s = pin_s[0];

    // The synchroniser lags the pin by two cycles, so the ready it shows early in an access
    // was sampled before our strobe fell. A low left over from the previous access would
    // otherwise end this one at once; those cycles are skipped. The cost is a floor of three
    // cycles per access, which the synchroniser imposes anyway.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lat_q <= 2'h0;
        end else if (state_q != PBH_ACCESS) begin
            lat_q <= 2'h0;
        end else if (lat_q != 2'(`PBH_RDY_SKIP)) begin
            lat_q <= lat_q + 2'h1;
        end
    end
    assign acc_done = (state_q == PBH_ACCESS) && !rdy_s && (lat_q == 2'(`PBH_RDY_SKIP));

    // The ignore bit overrides a low hold request.
    assign hold_want = !hold_s && !ignore_release_bit_in;

    // A new request is only taken when idle and no hold is pending.
    assign req_ready_out = (state_q == PBH_IDLE) && !hold_want && shz_s;

    // Sequencer: idle, one access until ready, or held.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= PBH_IDLE;
        end else begin
            unique case (state_q)
                PBH_IDLE: begin
                    if (hold_want) begin
                        state_q <= PBH_HELD;
                    end else if (req_valid_in && shz_s) begin
                        state_q <= PBH_ACCESS;
                    end
                end
                PBH_ACCESS: begin
                    // Hold never cuts a transfer short; ready ends it first.
                    if (acc_done) begin
                        state_q <= PBH_IDLE;
                    end
                end
                PBH_HELD: begin
                    if (!hold_want) begin
                        state_q <= PBH_IDLE;
                    end
                end
            endcase
        end
    end

    // Latch the request and decode its page when it is taken.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cur_q <= '0;
            page_q <= '1;
        end else if (req_ready_out && req_valid_in) begin
            cur_q <= req_in;
            for (int i = 0; i < NP; i++) begin
                page_q[i] <= !(req_in.addr[AW-1:`PBH_PAGE_LSB] == 2'(i));
            end
        end else if (acc_done) begin
            page_q <= '1;
        end
    end

    // Capture read data and pulse completion when ready is seen.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= '0;
            rsp_q <= 1'b0;
        end else begin
            rsp_q <= acc_done;
            if (acc_done && cur_q.rd) begin
                rdata_q <= ext_data_bus_in;
            end
        end
    end

    // Keeper follows the bus only during our own accesses: our write data, or the device's data on a read.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            keep_q <= `PBH_KEEP_RST;
        end else if (ext_data_bus_oe_out) begin
            keep_q <= cur_q.wdata;
        end else if (state_q == PBH_ACCESS && cur_q.rd) begin
            keep_q <= ext_data_bus_in;
        end
    end

    // Bus drivers are on outside hold and shutdown; reset also gates off every enable but the strobe's and the acknowledge's.
    assign bus_on = (state_q != PBH_HELD) && shz_s;
    assign ext_addr_bus_out = cur_q.addr;
    assign ext_addr_bus_oe_out = bus_on && rstn_in;
    assign rd_wr_n_out = (state_q == PBH_ACCESS) ? cur_q.rd : 1'b1;
    assign rd_wr_n_oe_out = bus_on && rstn_in;
    assign access_strobe_n_out = !(state_q == PBH_ACCESS);
    // The strobe stays driven through reset, which keeps it inactive there.
    assign access_strobe_n_oe_out = bus_on;
    assign page_select_n_out = page_q;
    assign page_select_n_oe_out = bus_on && rstn_in;
    // During write access the data is driven; otherwise the keeper value waits.
    assign ext_data_bus_out = (state_q == PBH_ACCESS && !cur_q.rd) ? cur_q.wdata : keep_q;
    assign ext_data_bus_oe_out = bus_on && rstn_in && state_q == PBH_ACCESS && !cur_q.rd;
    // Acknowledge tracks the held state, entered only from idle with drivers off.
    assign bus_release_ack_n_out = !(state_q == PBH_HELD);
    assign bus_release_ack_n_oe_out = shz_s;
    assign rsp_valid_out = rsp_q;
    assign rsp_rdata_out = rdata_q;

    property p_ack_floats;
        @(posedge clk_in) disable iff (!rstn_in)
        !bus_release_ack_n_out |-> !ext_addr_bus_oe_out && !ext_data_bus_oe_out && !access_strobe_n_oe_out;
    endproperty
    a_ack_floats: assert property (p_ack_floats) else $error("ack while bus driven");

    property p_no_hold_mid;
        @(posedge clk_in) disable iff (!rstn_in)
        state_q == PBH_ACCESS && rdy_s |=> state_q == PBH_ACCESS;
    endproperty
    a_no_hold_mid: assert property (p_no_hold_mid) else $error("access left without ready");

    sequence s_held;
        state_q == PBH_HELD;
    endsequence
    property p_release;
        @(posedge clk_in) disable iff (!rstn_in)
        s_held ##0 (hold_s || ignore_release_bit_in) |=> bus_release_ack_n_out;
    endproperty
    a_release: assert property (p_release) else $error("ack not released");

    property p_hold_grab;
        @(posedge clk_in) disable iff (!rstn_in)
        state_q == PBH_IDLE && hold_want |=> !bus_release_ack_n_out;
    endproperty
    a_hold_grab: assert property (p_hold_grab) else $error("hold not acknowledged");

    property p_no_start_held;
        @(posedge clk_in) disable iff (!rstn_in)
        hold_want |-> !req_ready_out;
    endproperty
    a_no_start_held: assert property (p_no_start_held) else $error("request taken under hold");

    property p_dir;
        @(posedge clk_in) disable iff (!rstn_in)
        state_q == PBH_ACCESS |-> rd_wr_n_out == cur_q.rd && !access_strobe_n_out;
    endproperty
    a_dir: assert property (p_dir) else $error("direction or strobe wrong");

    property p_page_onehot;
        @(posedge clk_in) disable iff (!rstn_in)
        state_q == PBH_ACCESS |-> $onehot(~page_select_n_out);
    endproperty
    a_page_onehot: assert property (p_page_onehot) else $error("page strobe not single");

    property p_shz;
        @(posedge clk_in) disable iff (!rstn_in)
        !shz_s |-> !bus_release_ack_n_oe_out && !rd_wr_n_oe_out && !page_select_n_oe_out;
    endproperty
    a_shz: assert property (p_shz) else $error("pin driven in shutdown");

    property p_rsp;
        @(posedge clk_in) disable iff (!rstn_in)
        acc_done |=> rsp_valid_out && state_q != PBH_ACCESS;
    endproperty
    a_rsp: assert property (p_rsp) else $error("completion missing");

    // A stale ready in the first cycles of an access must never end it.
    property p_ready_skip;
        @(posedge clk_in) disable iff (!rstn_in)
        state_q == PBH_ACCESS && lat_q != 2'(`PBH_RDY_SKIP) |=> state_q == PBH_ACCESS;
    endproperty
    a_ready_skip: assert property (p_ready_skip) else $error("access ended on stale ready");
endmodule

// *** test/pbh_mem_model.sv ***
`timescale 1ns/1ps
// Far-side memory: answers each strobed access after a set number of wait cycles.
module pbh_mem_model (
    input wire logic clk_in, // Clock.
    input wire logic rstn_in, // Reset, active low.
    input wire logic [3:0] waits_in, // Wait cycles before ready.
    input wire logic strobe_n_in, // Access strobe level on the wire.
    input wire logic rd_in, // Direction level on the wire.
    input wire logic [23:0] addr_in, // Address on the wire.
    input wire logic [31:0] data_in, // Data wire level.
    output logic ready_n_out, // Ready, active low.
    output logic [31:0] data_out, // Read data.
    output logic data_oe_out, // Read data drive enable.
    output logic [31:0] wr_data_out // Last word written.
);
    logic [3:0] cnt_q; // Cycles spent in the current access.
    // Count the waits; the count restarts whenever the strobe is high.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_q <= 4'h0;
            wr_data_out <= 32'h0;
        end else if (strobe_n_in) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            if (!ready_n_out && !rd_in) begin
                wr_data_out <= data_in; // Capture the write once ready is given.
            end
        end
    end
    // Ready drops at once with the strobe, so no stale ready leaks into the next access.
    assign ready_n_out = strobe_n_in || (cnt_q < waits_in);
    assign data_oe_out = !strobe_n_in && rd_in;
    assign data_out = {8'h5a, addr_in};
endmodule

// *** test/pbh_port_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench: accesses on every page, hold, ignore bit and shutdown.
module pbh_port_tb;
    import pbh_pkg::*;
    logic clk_in = 1'b0, rstn_in = 1'b0, shz_n = 1'b1, ign = 1'b0, valid = 1'b0, hold_n = 1'b1;
    logic ready, rsp_v, addr_oe, d_oe, rw, rw_oe, stb, stb_oe, page_oe, ack, ack_oe, rdy_n, m_oe;
    logic [31:0] rdata, d_out, bus, m_data, m_wr;
    logic [23:0] addr;
    logic [3:0] page;
    logic [3:0] waits = 4'h0;
    pbh_req_s req = '0;
    int n_mismatch = 0, comparisons = 0;
    always #25 clk_in = ~clk_in;
    // Wire level: the port, else the memory, else the port's keeper value.
    assign bus = (m_oe && !d_oe) ? m_data : d_out;
    pbh_port pbh_port_inst (.clk_in(clk_in), .rstn_in(rstn_in), .shutdown_float_n_in(shz_n),
        .ignore_release_bit_in(ign), .req_valid_in(valid), .req_ready_out(ready), .req_in(req),
        .rsp_valid_out(rsp_v), .rsp_rdata_out(rdata), .ext_addr_bus_out(addr), .ext_addr_bus_oe_out(addr_oe),
        .ext_data_bus_in(bus), .ext_data_bus_out(d_out), .ext_data_bus_oe_out(d_oe), .rd_wr_n_out(rw),
        .rd_wr_n_oe_out(rw_oe), .access_strobe_n_out(stb), .access_strobe_n_oe_out(stb_oe),
        .page_select_n_out(page), .page_select_n_oe_out(page_oe), .ready_n_in(rdy_n),
        .hold_req_n_in(hold_n), .bus_release_ack_n_out(ack), .bus_release_ack_n_oe_out(ack_oe));
    pbh_mem_model pbh_mem_model_inst (.clk_in(clk_in), .rstn_in(rstn_in), .waits_in(waits),
        .strobe_n_in(stb), .rd_in(rw), .addr_in(addr), .data_in(bus), .ready_n_out(rdy_n),
        .data_out(m_data), .data_oe_out(m_oe), .wr_data_out(m_wr));
    // Inputs change a fixed 2 ns after the rising edge.
    task automatic tick();
        @(posedge clk_in);
        #2;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Wait a bounded time for the acknowledge to reach a level.
    task automatic wait_ack(input logic v);
        int n;
        n = 0;
        while (ack !== v && n < 12) begin
            tick();
            n++;
        end
        chk("ack", v, ack);
        if (ack !== v) stop_test();
    endtask
    // One access: checks the pins during the strobe, the latency and the data.
    task automatic access(input logic rd, input logic [23:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        // A port that never becomes ready ends the run as a failure.
        if (ready !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED ready expected 1 seen %b", ready);
            stop_test();
        end
        req = '{rd: rd, addr: a, wdata: wd};
        valid = 1'b1;
        tick();
        valid = 1'b0;
        chk("strobe", 1'b0, stb);
        chk("direction", rd, rw);
        chk("page", {28'h0, ~(4'h1 << a[23:22])}, page);
        chk("addr", a, addr);
        chk("data oe", !rd, d_oe);
        n = 1;
        while (rsp_v !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        if (rsp_v !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED completion expected 1 seen %b", rsp_v);
            stop_test();
        end
        chk("latency", 1'b1, n >= waits + 4);
        chk("data", rd ? {8'h5a, a} : wd, rd ? rdata : m_wr);
    endtask
    // Reads and writes on every page, prompt and slow; keeper after each write.
    task automatic test_pages();
        for (int i = 0; i < 8; i++) begin
            waits = (i < 4) ? 4'h0 : 4'h5;
            access(1'b1, {i[1:0], 22'h0abc1 + 22'(i)}, 32'h0);
            access(1'b0, {i[1:0], 22'h12340}, 32'hc0de_0000 + 32'(i));
            tick();
            chk("keeper", 32'hc0de_0000 + 32'(i), bus);
        end
    endtask
    // Hold raised as the access is requested, reaching the port mid-access: the access finishes, then the bus floats.
    task automatic test_hold();
        waits = 4'h8;
        hold_n = 1'b0;
        access(1'b1, 24'h4000ee, 32'h0);
        wait_ack(1'b0);
        valid = 1'b1;
        repeat (4) tick();
        chk("float", 5'h00, {addr_oe, d_oe, rw_oe, stb_oe, page_oe});
        chk("refuse", 1'b0, ready);
        valid = 1'b0;
        hold_n = 1'b1;
        wait_ack(1'b1);
        hold_n = 1'b0;
        wait_ack(1'b0);
        ign = 1'b1;
        wait_ack(1'b1);
        waits = 4'h1;
        access(1'b0, 24'hc00001, 32'h5555_aaaa);
        ign = 1'b0;
        hold_n = 1'b1;
        repeat (4) tick();
    endtask
    // Shutdown floats every pin; a reset afterwards restores working order.
    task automatic test_shutdown();
        shz_n = 1'b0;
        repeat (5) tick();
        chk("shutdown", 7'h00, {addr_oe, d_oe, rw_oe, stb_oe, page_oe, ack_oe, ready});
        shz_n = 1'b1;
        rstn_in = 1'b0;
        repeat (4) tick();
        chk("reset float", 5'h02, {addr_oe, d_oe, rw_oe, stb_oe, page_oe});
        rstn_in = 1'b1;
        access(1'b1, 24'h800010, 32'h0);
    endtask
    initial begin
        repeat (4) tick();
        chk("reset float", 5'h02, {addr_oe, d_oe, rw_oe, stb_oe, page_oe});
        rstn_in = 1'b1;
        test_pages();
        test_hold();
        test_shutdown();
        stop_test();
    end
endmodule
